// >>> csxr_defs.vh
/*
  csxr_defs.vh: index map, field positions, reset values and lock key for
  the cursor and system extension register bank.
  assumes: included by its bare name from the bank's design files.
*/
`ifndef CSXR_DEFS_VH
`define CSXR_DEFS_VH

// ----------------------------------------------------------------------
// register indices on the index/data port
// ----------------------------------------------------------------------
`define CSXR_IDX_LOCK       8'h39
`define CSXR_IDX_CMODE      8'h45
`define CSXR_IDX_ORGX_H     8'h46
`define CSXR_IDX_ORGX_L     8'h47
`define CSXR_IDX_ORGY_H     8'h48
`define CSXR_IDX_ORGY_L     8'h49
`define CSXR_IDX_FGSTK      8'h4A
`define CSXR_IDX_BGSTK      8'h4B
`define CSXR_IDX_STA_H      8'h4C
`define CSXR_IDX_STA_L      8'h4D
`define CSXR_IDX_PDX        8'h4E
`define CSXR_IDX_PDY        8'h4F
`define CSXR_IDX_SCTL1      8'h50
`define CSXR_IDX_SCTL2      8'h51
`define CSXR_IDX_FWFLG1     8'h52
`define CSXR_IDX_MCTL1      8'h53

// ----------------------------------------------------------------------
// lock key, reset values and last colour stack entry
// ----------------------------------------------------------------------
`define CSXR_KEY_TOP        3'h5
`define CSXR_RST_BYTE       8'h00
`define CSXR_RST_ORG        11'h000
`define CSXR_STK_LAST       2'h2

// ----------------------------------------------------------------------
// writable-bit masks (reserved bits are stored as zero)
// ----------------------------------------------------------------------
`define CSXR_MSK_H3         8'h07
`define CSXR_MSK_H4         8'h0F
`define CSXR_MSK_P6         8'h3F
`define CSXR_MSK_SCTL1      8'hF5
`define CSXR_MSK_SCTL2      8'h3F
`define CSXR_MSK_MCTL1      8'h51

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CSXR_PXL_HI         5
`define CSXR_PXL_LO         4
`define CSXR_GESW_B2        0
`define CSXR_GESW_HI        7
`define CSXR_GESW_LO        6
`define CSXR_BREQ_BIT       2
`define CSXR_DSAD_HI        1
`define CSXR_DSAD_LO        0
`define CSXR_CBAD_HI        3
`define CSXR_CBAD_LO        2
`define CSXR_LSW_HI         5
`define CSXR_LSW_LO         4
`define CSXR_WPB_BIT        0
`define CSXR_MMIO_BIT       4
`define CSXR_SWP_BIT        6

`endif

// >>> csxr_color_stack.v
/*
  csxr_color_stack.v: three-entry byte stack for one cursor colour.
  assumes: the owner supplies the shared pointer and a one-cycle write pulse.
*/
`timescale 1ns/100ps
`default_nettype none
`include "csxr_defs.vh"

module csxr_color_stack (
  input  wire        clock_i,
  input  wire        nrst_i,
  input  wire        wr_i,
  input  wire [1:0]  ptr_i,
  input  wire [7:0]  wdata_i,
  output wire [23:0] color_o,
  output reg  [7:0]  rdata_o
);

  reg [7:0] ent_ff [0:2];
  integer   k;

  // ----------------------------------------------------------------------
  // storage; a pointer past the last entry drops the byte
  // ----------------------------------------------------------------------
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (k = 0; k < 3; k = k + 1) begin
        ent_ff[k] <= `CSXR_RST_BYTE;
      end
    end else if (wr_i && (ptr_i <= `CSXR_STK_LAST)) begin
      ent_ff[ptr_i] <= wdata_i;
    end
  end

  // registered read of the entry under the pointer
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= `CSXR_RST_BYTE;
    end else if (ptr_i <= `CSXR_STK_LAST) begin
      rdata_o <= ent_ff[ptr_i];
    end else begin
      rdata_o <= `CSXR_RST_BYTE;
    end
  end

  assign color_o = {ent_ff[2], ent_ff[1], ent_ff[0]};

endmodule // csxr_color_stack
`default_nettype wire

// >>> csxr_lock.v
/*
  csxr_lock.v: tracks the register lock key and reports unlock.
  assumes: the lock register write pulse comes from the same clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
`include "csxr_defs.vh"

module csxr_lock (
  input  wire       clock_i,
  input  wire       nrst_i,
  input  wire       wr_i,
  input  wire [7:0] wdata_i,
  output reg  [7:0] key_o,
  output wire       unlocked_o
);

  // ----------------------------------------------------------------------
  // key register; unlocked while the top three bits hold the key
  // ----------------------------------------------------------------------
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      key_o <= `CSXR_RST_BYTE;
    end else if (wr_i) begin
      key_o <= wdata_i;
    end
  end

  assign unlocked_o = (key_o[7:5] == `CSXR_KEY_TOP);

endmodule // csxr_lock
`default_nettype wire

// >>> csxr_bank.v
/*
  csxr_bank.v: cursor and system extension register bank behind an
  index/data port pair, with lock key and shared colour stack pointer.
  assumes: index and data strobes are one-cycle pulses on clock_i, issued by
  host-port logic on the same clock; the cursor mode register lives elsewhere
  and only its read strobe leaves here.
  reserved bits are stored as zero; software must still write them as zero.
  a stack read needs one quiet cycle after a stack write or mode read.
*/
`timescale 1ns/100ps
`default_nettype none
`include "csxr_defs.vh"

module csxr_bank (
  input  wire        clock_i,
  input  wire        nrst_i,
  input  wire        idx_wr_i,
  input  wire [7:0]  idx_wdata_i,
  input  wire        data_wr_i,
  input  wire        data_rd_i,
  input  wire [7:0]  data_wdata_i,
  output reg  [7:0]  data_rdata_o,
  output wire [7:0]  index_o,
  output wire        unlocked_o,
  output wire        mode_rd_o,
  input  wire        new_dsad_prog_i,
  input  wire        new_cbad_prog_i,
  input  wire        legacy_width_bit8_i,
  output reg  [10:0] cursor_origin_x_o,
  output reg  [10:0] cursor_origin_y_o,
  output wire [23:0] cursor_fg_color_o,
  output wire [23:0] cursor_bg_color_o,
  output wire [11:0] cursor_storage_start_o,
  output wire [5:0]  cursor_pattern_x_offset_o,
  output wire [5:0]  cursor_pattern_y_offset_o,
  output wire [1:0]  engine_pixel_size_o,
  output wire [2:0]  engine_screen_width_code_o,
  output wire        bus_request_enable_o,
  output wire [1:0]  display_start_ext_bits_o,
  output wire        display_start_ext_valid_o,
  output wire [1:0]  cpu_base_ext_bits_o,
  output wire        cpu_base_ext_valid_o,
  output wire [1:0]  logical_width_ext_bits_o,
  output wire        legacy_width_bit8_o,
  output wire [7:0]  firmware_flag_o,
  output wire        write_mask_enable_o,
  output wire        mapped_io_enable_o,
  output wire        nibble_swap_enable_o
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  // index and stored bytes; origin bytes wait here
  reg  [7:0]  index_ff;
  reg  [7:0]  orgx_h_ff;
  reg  [7:0]  orgx_l_ff;
  reg  [7:0]  orgy_h_ff;
  reg  [7:0]  orgy_l_ff;
  reg  [7:0]  sta_h_ff;
  reg  [7:0]  sta_l_ff;
  reg  [7:0]  pdx_ff;
  reg  [7:0]  pdy_ff;
  reg  [7:0]  sctl1_ff;
  reg  [7:0]  sctl2_ff;
  reg  [7:0]  fwflg_ff;
  reg  [7:0]  mctl1_ff;
  // shared stack pointer and next values
  reg  [1:0]  ptr_ff;
  reg  [1:0]  nxt_ptr;
  reg  [7:0]  nxt_rdata;
  // key, stack read data and write strobes
  wire [7:0]  key;
  wire [7:0]  fg_rdata;
  wire [7:0]  bg_rdata;
  wire        wr_fg;
  wire        wr_bg;
  wire        wr_lock;

  // decode of protected indices, used by the write path
  // the lock register sits below this range and is never protected
  function prot_hit;
    input [7:0] idx;
    begin
      prot_hit = (idx >= `CSXR_IDX_ORGX_H) && (idx <= `CSXR_IDX_MCTL1);
    end
  endfunction

  // ----------------------------------------------------------------------
  // index register and lock key
  // ----------------------------------------------------------------------
  // index loads on every index strobe, locked or not
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      index_ff <= `CSXR_RST_BYTE;
    end else if (idx_wr_i) begin
      index_ff <= idx_wdata_i;
    end
  end

  // the lock stays reachable so a locked bank can be opened
  assign index_o = index_ff;
  assign wr_lock = data_wr_i && (index_ff == `CSXR_IDX_LOCK);

  // key holder; unlock is a compare on its top bits
  csxr_lock u_lock (
    .clock_i    (clock_i),
    .nrst_i     (nrst_i),
    .wr_i       (wr_lock),
    .wdata_i    (data_wdata_i),
    .key_o      (key),
    .unlocked_o (unlocked_o)
  );

  // mode register read strobe passes out and clears the stack pointer
  // a locked mode read is not taken; the pointer stays put
  assign mode_rd_o = data_rd_i && (index_ff == `CSXR_IDX_CMODE) && unlocked_o;

  // ----------------------------------------------------------------------
  // plain byte registers; locked writes are dropped
  // ----------------------------------------------------------------------
  // one byte per strobe, picked by the index
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      orgx_h_ff <= `CSXR_RST_BYTE;
      orgx_l_ff <= `CSXR_RST_BYTE;
      orgy_h_ff <= `CSXR_RST_BYTE;
      orgy_l_ff <= `CSXR_RST_BYTE;
      sta_h_ff  <= `CSXR_RST_BYTE;
      sta_l_ff  <= `CSXR_RST_BYTE;
      pdx_ff    <= `CSXR_RST_BYTE;
      pdy_ff    <= `CSXR_RST_BYTE;
      sctl1_ff  <= `CSXR_RST_BYTE;
      sctl2_ff  <= `CSXR_RST_BYTE;
      fwflg_ff  <= `CSXR_RST_BYTE;
      mctl1_ff  <= `CSXR_RST_BYTE;
    end else if (data_wr_i && unlocked_o && prot_hit(index_ff)) begin
      // reserved bits are masked off so they read back as zero
      case (index_ff)
        `CSXR_IDX_ORGX_H: begin
          orgx_h_ff <= data_wdata_i & `CSXR_MSK_H3;
        end
        `CSXR_IDX_ORGX_L: begin
          orgx_l_ff <= data_wdata_i;
        end
        `CSXR_IDX_ORGY_H: begin
          orgy_h_ff <= data_wdata_i & `CSXR_MSK_H3;
        end
        `CSXR_IDX_ORGY_L: begin
          orgy_l_ff <= data_wdata_i;
        end
        `CSXR_IDX_STA_H: begin
          sta_h_ff <= data_wdata_i & `CSXR_MSK_H4;
        end
        `CSXR_IDX_STA_L: begin
          sta_l_ff <= data_wdata_i;
        end
        `CSXR_IDX_PDX: begin
          pdx_ff <= data_wdata_i & `CSXR_MSK_P6;
        end
        `CSXR_IDX_PDY: begin
          pdy_ff <= data_wdata_i & `CSXR_MSK_P6;
        end
        `CSXR_IDX_SCTL1: begin
          sctl1_ff <= data_wdata_i & `CSXR_MSK_SCTL1;
        end
        `CSXR_IDX_SCTL2: begin
          sctl2_ff <= data_wdata_i & `CSXR_MSK_SCTL2;
        end
        `CSXR_IDX_FWFLG1: begin
          fwflg_ff <= data_wdata_i;
        end
        `CSXR_IDX_MCTL1: begin
          mctl1_ff <= data_wdata_i & `CSXR_MSK_MCTL1;
        end
        default: begin
          // reached inside the range only by the stack indices 0x4A and 0x4B; nothing changes
          fwflg_ff <= fwflg_ff;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // working cursor position, loaded as one unit
  // ----------------------------------------------------------------------
  // x and y move together so the cursor never shows half-updated
  // pending bytes alone never move the cursor
  // y high comes from the bus; its flop updates on this edge
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cursor_origin_x_o <= `CSXR_RST_ORG;
      cursor_origin_y_o <= `CSXR_RST_ORG;
    end else if (data_wr_i && unlocked_o && (index_ff == `CSXR_IDX_ORGY_H)) begin
      cursor_origin_x_o <= {orgx_h_ff[2:0], orgx_l_ff};
      cursor_origin_y_o <= {data_wdata_i[2:0], orgy_l_ff};
    end
  end

  // ----------------------------------------------------------------------
  // colour stacks and their shared pointer
  // ----------------------------------------------------------------------
  // one write strobe per stack, only while unlocked
  assign wr_fg = data_wr_i && unlocked_o && (index_ff == `CSXR_IDX_FGSTK);
  assign wr_bg = data_wr_i && unlocked_o && (index_ff == `CSXR_IDX_BGSTK);

  // a mode read in the same cycle as a stack write leaves the pointer at 0
  // past the last entry the pointer sticks; writes drop
  always @* begin
    nxt_ptr = ptr_ff;
    if (mode_rd_o) begin
      nxt_ptr = 2'h0;
    end else if ((wr_fg || wr_bg) && (ptr_ff <= `CSXR_STK_LAST)) begin
      nxt_ptr = ptr_ff + 2'h1;
    end
  end

  // pointer register
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ptr_ff <= 2'h0;
    end else begin
      ptr_ff <= nxt_ptr;
    end
  end

  // foreground entries fill 0, 1, 2 in write order
  csxr_color_stack u_fg (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .wr_i    (wr_fg),
    .ptr_i   (ptr_ff),
    .wdata_i (data_wdata_i),
    .color_o (cursor_fg_color_o),
    .rdata_o (fg_rdata)
  );

  // background stack shares the pointer
  csxr_color_stack u_bg (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .wr_i    (wr_bg),
    .ptr_i   (ptr_ff),
    .wdata_i (data_wdata_i),
    .color_o (cursor_bg_color_o),
    .rdata_o (bg_rdata)
  );

  // ----------------------------------------------------------------------
  // read path: data registered on the read strobe
  // ----------------------------------------------------------------------
  // the lock always reads back; a locked bank reads zero
  // stack data is one edge old, hence the quiet cycle
  always @* begin
    nxt_rdata = `CSXR_RST_BYTE;
    if (index_ff == `CSXR_IDX_LOCK) begin
      nxt_rdata = key;
    end else if (unlocked_o) begin
      case (index_ff)
        `CSXR_IDX_ORGX_H: nxt_rdata = orgx_h_ff;
        `CSXR_IDX_ORGX_L: nxt_rdata = orgx_l_ff;
        `CSXR_IDX_ORGY_H: nxt_rdata = orgy_h_ff;
        `CSXR_IDX_ORGY_L: nxt_rdata = orgy_l_ff;
        `CSXR_IDX_FGSTK:  nxt_rdata = fg_rdata;
        `CSXR_IDX_BGSTK:  nxt_rdata = bg_rdata;
        `CSXR_IDX_STA_H:  nxt_rdata = sta_h_ff;
        `CSXR_IDX_STA_L:  nxt_rdata = sta_l_ff;
        `CSXR_IDX_PDX:    nxt_rdata = pdx_ff;
        `CSXR_IDX_PDY:    nxt_rdata = pdy_ff;
        `CSXR_IDX_SCTL1:  nxt_rdata = sctl1_ff;
        `CSXR_IDX_SCTL2:  nxt_rdata = sctl2_ff;
        `CSXR_IDX_FWFLG1: nxt_rdata = fwflg_ff;
        `CSXR_IDX_MCTL1:  nxt_rdata = mctl1_ff;
        default:          nxt_rdata = `CSXR_RST_BYTE;
      endcase
    end
  end

  // read data holds until the next read strobe
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_rdata_o <= `CSXR_RST_BYTE;
    end else if (data_rd_i) begin
      data_rdata_o <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // fields to the consuming logic
  // ----------------------------------------------------------------------
  // plain fields straight from the stored bytes
  assign cursor_storage_start_o     = {sta_h_ff[3:0], sta_l_ff};
  assign cursor_pattern_x_offset_o  = pdx_ff[5:0];
  assign cursor_pattern_y_offset_o  = pdy_ff[5:0];
  assign engine_pixel_size_o        = sctl1_ff[`CSXR_PXL_HI:`CSXR_PXL_LO];
  // width code takes its top bit from bit 0
  assign engine_screen_width_code_o = {sctl1_ff[`CSXR_GESW_B2],
                                       sctl1_ff[`CSXR_GESW_HI:`CSXR_GESW_LO]};
  // bus request enable only passes through
  assign bus_request_enable_o       = sctl1_ff[`CSXR_BREQ_BIT];
  assign display_start_ext_bits_o   = sctl2_ff[`CSXR_DSAD_HI:`CSXR_DSAD_LO];
  // legacy base bits count only while newer bits are unused
  assign display_start_ext_valid_o  = ~new_dsad_prog_i;
  assign cpu_base_ext_bits_o        = sctl2_ff[`CSXR_CBAD_HI:`CSXR_CBAD_LO];
  assign cpu_base_ext_valid_o       = ~new_cbad_prog_i;
  assign logical_width_ext_bits_o   = sctl2_ff[`CSXR_LSW_HI:`CSXR_LSW_LO];
  // legacy bit 8 only counts while the new width bits are zero
  assign legacy_width_bit8_o        = legacy_width_bit8_i &
                                      (logical_width_ext_bits_o == 2'h0);
  // firmware flag byte is scratch for boot code
  assign firmware_flag_o            = fwflg_ff;
  // memory control bits leave as levels
  assign write_mask_enable_o        = mctl1_ff[`CSXR_WPB_BIT];
  assign mapped_io_enable_o         = mctl1_ff[`CSXR_MMIO_BIT];
  assign nibble_swap_enable_o       = mctl1_ff[`CSXR_SWP_BIT];

endmodule // csxr_bank
`default_nettype wire

// >>> csxr_bank_asserts.sv
/*
  csxr_bank_asserts.sv: concurrent checks on the ports of the register bank.
  assumes: bound to csxr_bank; one clock, asynchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module csxr_bank_asserts (
  input wire logic        clock_i,
  input wire logic        nrst_i,
  input wire logic        data_wr_i,
  input wire logic        data_rd_i,
  input wire logic [7:0]  data_wdata_i,
  input wire logic [7:0]  data_rdata_o,
  input wire logic [7:0]  index_o,
  input wire logic        unlocked_o,
  input wire logic        mode_rd_o,
  input wire logic        new_dsad_prog_i,
  input wire logic        new_cbad_prog_i,
  input wire logic        legacy_width_bit8_i,
  input wire logic [10:0] cursor_origin_x_o,
  input wire logic [10:0] cursor_origin_y_o,
  input wire logic [23:0] cursor_fg_color_o,
  input wire logic [1:0]  engine_pixel_size_o,
  input wire logic [2:0]  engine_screen_width_code_o,
  input wire logic        display_start_ext_valid_o,
  input wire logic        cpu_base_ext_valid_o,
  input wire logic [1:0]  logical_width_ext_bits_o,
  input wire logic        legacy_width_bit8_o,
  input wire logic        write_mask_enable_o,
  input wire logic        mapped_io_enable_o,
  input wire logic        nibble_swap_enable_o
);
  // ----------------------------------------------------------------------
  // timing and steps
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // accepted write at one index; locked writes do not count
  sequence s_wr_at(idx);
    data_wr_i && unlocked_o && index_o == idx;
  endsequence
  // pointer cleared by a mode read, then two idle cycles
  sequence s_ptr_clear;
    mode_rd_o && !data_wr_i ##1 (!data_wr_i) [*2];
  endsequence

  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  a_origin_load: assert property (s_wr_at(8'h48) |=> cursor_origin_y_o[10:8] == $past(data_wdata_i[2:0]))
    else $error("origin high bits not loaded");
  a_origin_hold: assert property (!(data_wr_i && unlocked_o && index_o == 8'h48)
    |=> $stable(cursor_origin_x_o) && $stable(cursor_origin_y_o))
    else $error("working origin moved without a y high write");
  a_stack_first: assert property (s_ptr_clear ##1 s_wr_at(8'h4A) |=> cursor_fg_color_o[7:0] == $past(data_wdata_i))
    else $error("stack write after mode read missed entry zero");
  a_unlock_key: assert property (data_wr_i && index_o == 8'h39 |=> unlocked_o == ($past(data_wdata_i[7:5]) == 3'b101))
    else $error("unlock state wrong after key write");
  a_locked_hold: assert property (!unlocked_o && data_wr_i && index_o != 8'h39 |=> $stable({engine_pixel_size_o,
    engine_screen_width_code_o, logical_width_ext_bits_o, write_mask_enable_o, mapped_io_enable_o, nibble_swap_enable_o}))
    else $error("locked write changed a field");
  a_locked_read: assert property (!unlocked_o && data_rd_i && index_o >= 8'h46 && index_o <= 8'h53 |=> data_rdata_o == 8'h00)
    else $error("locked read returned data");
  a_engine_fields: assert property (s_wr_at(8'h50) |=> engine_screen_width_code_o == {$past(data_wdata_i[0]),
    $past(data_wdata_i[7:6])} && engine_pixel_size_o == $past(data_wdata_i[5:4]))
    else $error("engine fields not taken from write");
  a_mem_bits: assert property (s_wr_at(8'h53) |=> {nibble_swap_enable_o, mapped_io_enable_o, write_mask_enable_o}
    == {$past(data_wdata_i[6]), $past(data_wdata_i[4]), $past(data_wdata_i[0])})
    else $error("memory control bits not taken from write");
  a_width_gate: assert property (legacy_width_bit8_o == (legacy_width_bit8_i && logical_width_ext_bits_o == 2'b00))
    else $error("legacy width bit gating wrong");
  a_base_valid: assert property (display_start_ext_valid_o == !new_dsad_prog_i
    && cpu_base_ext_valid_o == !new_cbad_prog_i)
    else $error("legacy base bits validity wrong");
endmodule // csxr_bank_asserts

bind csxr_bank csxr_bank_asserts i_chk (.clock_i(clock_i), .nrst_i(nrst_i), .data_wr_i(data_wr_i),
  .data_rd_i(data_rd_i), .data_wdata_i(data_wdata_i), .data_rdata_o(data_rdata_o), .index_o(index_o),
  .unlocked_o(unlocked_o), .mode_rd_o(mode_rd_o), .new_dsad_prog_i(new_dsad_prog_i),
  .new_cbad_prog_i(new_cbad_prog_i), .legacy_width_bit8_i(legacy_width_bit8_i),
  .cursor_origin_x_o(cursor_origin_x_o), .cursor_origin_y_o(cursor_origin_y_o),
  .cursor_fg_color_o(cursor_fg_color_o), .engine_pixel_size_o(engine_pixel_size_o),
  .engine_screen_width_code_o(engine_screen_width_code_o), .display_start_ext_valid_o(display_start_ext_valid_o),
  .cpu_base_ext_valid_o(cpu_base_ext_valid_o), .logical_width_ext_bits_o(logical_width_ext_bits_o),
  .legacy_width_bit8_o(legacy_width_bit8_o), .write_mask_enable_o(write_mask_enable_o),
  .mapped_io_enable_o(mapped_io_enable_o), .nibble_swap_enable_o(nibble_swap_enable_o));
`default_nettype wire

// >>> csxr_bank_tb_top.sv
/*
  csxr_bank_tb_top.sv: self-checking bench driving the index/data port.
  assumes: inputs change at the falling edge; read data settles one edge later.
*/
`timescale 1ns/100ps
`default_nettype none
module csxr_bank_tb_top;
  logic clock_i, nrst_i = 0, idx_wr_i = 0, data_wr_i = 0, data_rd_i = 0;
  logic new_dsad_prog_i = 0, new_cbad_prog_i = 0, legacy_width_bit8_i = 1;
  logic [7:0]  idx_wdata_i = 0, data_wdata_i = 0, data_rdata_o, firmware_flag_o, idx_o;
  logic        unlocked_o, wpb_o, mmio_o, swp_o, legacy_o, dsad_v, cbad_v, mode_o, breq_o;
  logic [10:0] org_x, org_y;
  logic [23:0] fg, bg;
  logic [11:0] sta;
  logic [5:0]  pdx, pdy;
  logic [1:0]  pix_o, dsad, cbad, lsw;
  logic [2:0]  gesw;
  logic [15:0] regs [10] = '{16'h4607, 16'h47FF, 16'h4807, 16'h49FF, 16'h4C0F, 16'h4DFF, 16'h4E3F, 16'h4F3F, 16'h513F, 16'h52FF};
  logic [1:0]  pix [3] = '{2'b00, 2'b01, 2'b11};
  logic [7:0]  mvals [3] = '{8'h01, 8'h10, 8'h40};
  int mismatches = 0, comparisons = 0, cycles = 0, k;

  csxr_bank i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .idx_wr_i(idx_wr_i), .idx_wdata_i(idx_wdata_i),
    .data_wr_i(data_wr_i), .data_rd_i(data_rd_i), .data_wdata_i(data_wdata_i), .data_rdata_o(data_rdata_o),
    .index_o(idx_o), .unlocked_o(unlocked_o), .mode_rd_o(mode_o), .new_dsad_prog_i(new_dsad_prog_i),
    .new_cbad_prog_i(new_cbad_prog_i), .legacy_width_bit8_i(legacy_width_bit8_i), .cursor_origin_x_o(org_x),
    .cursor_origin_y_o(org_y), .cursor_fg_color_o(fg), .cursor_bg_color_o(bg), .cursor_storage_start_o(sta),
    .cursor_pattern_x_offset_o(pdx), .cursor_pattern_y_offset_o(pdy), .engine_pixel_size_o(pix_o),
    .engine_screen_width_code_o(gesw), .bus_request_enable_o(breq_o), .display_start_ext_bits_o(dsad),
    .display_start_ext_valid_o(dsad_v), .cpu_base_ext_bits_o(cbad), .cpu_base_ext_valid_o(cbad_v),
    .logical_width_ext_bits_o(lsw), .legacy_width_bit8_o(legacy_o), .firmware_flag_o(firmware_flag_o),
    .write_mask_enable_o(wpb_o), .mapped_io_enable_o(mmio_o), .nibble_swap_enable_o(swp_o));

  // ----------------------------------------------------------------------
  // clock, hang guard and reporting
  // ----------------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      $display("[FAIL] run time expected under 3000 seen %0d", cycles);
      end_sim();
    end
  end
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end
    else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ----------------------------------------------------------------------
  // port access: one strobe per falling edge, dropped on the next
  // ----------------------------------------------------------------------
  task automatic put_idx(input logic [7:0] i);
    @(negedge clock_i);
    idx_wr_i = 1'b1;
    idx_wdata_i = i;
    @(negedge clock_i);
    idx_wr_i = 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    put_idx(i);
    data_wr_i = 1'b1;
    data_wdata_i = d;
    @(negedge clock_i);
    data_wr_i = 1'b0;
  endtask
  task automatic pulse_rd(input logic [7:0] i);
    put_idx(i);
    data_rd_i = 1'b1;
    #1;
    if (i == 8'h45) chk("mode strobe", 1, mode_o);
    @(negedge clock_i);
    data_rd_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    pulse_rd(i);
    chk("read data", {16'h0000, e}, {16'h0000, data_rdata_o});
    chk("index", {16'h0000, i}, {16'h0000, idx_o});
  endtask

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(negedge clock_i);
    nrst_i = 1'b1;
    chk("unlocked", 0, unlocked_o);
    chk("mmio enable", 0, mmio_o);
    wr(8'h53, 8'h51);
    rd(8'h53, 8'h00);
    chk("mmio enable", 0, mmio_o);
    wr(8'h39, 8'hA0);
    chk("unlocked", 1, unlocked_o);
    $display("test lock done");
    // origin bytes stay pending until the y high byte lands
    wr(8'h46, 8'h05);
    wr(8'h47, 8'h34);
    wr(8'h49, 8'h78);
    chk("origin x", 0, org_x);
    chk("origin y", 0, org_y);
    wr(8'h48, 8'h03);
    chk("origin x", 11'h534, org_x);
    chk("origin y", 11'h378, org_y);
    $display("test origin done");
    // colour stacks share one pointer, cleared by a mode read
    pulse_rd(8'h45);
    for (k = 0; k < 3; k++) wr(8'h4A, 8'h11 * (k + 1));
    chk("fg colour", 24'h33_2211, fg);
    pulse_rd(8'h45);
    for (k = 0; k < 3; k++) wr(8'h4B, 8'h44 + 8'h11 * k);
    chk("bg colour", 24'h66_5544, bg);
    pulse_rd(8'h45);
    wr(8'h4A, 8'h77);
    wr(8'h4B, 8'h88);
    chk("fg colour", 24'h33_2277, fg);
    chk("bg colour", 24'h66_8844, bg);
    rd(8'h4A, 8'h33);
    $display("test stack done");
    // every writable bit set except in 0x50 and 0x53, reserved bits written as zero
    for (k = 0; k < 10; k++) begin
      wr(regs[k][15:8], regs[k][7:0]);
      rd(regs[k][15:8], regs[k][7:0]);
    end
    chk("origin y", 11'h778, org_y);
    chk("origin x", 11'h7FF, org_x);
    chk("firmware flag", 8'hFF, firmware_flag_o);
    chk("storage start", 12'hFFF, sta);
    chk("pattern x", 6'h3F, pdx);
    chk("pattern y", 6'h3F, pdy);
    $display("test readback done");
    // width codes 101 and 111 are reserved and never written
    for (k = 0; k < 8; k++) if (k != 5 && k != 7) begin
      wr(8'h50, {k[1:0], pix[k % 3], 1'b0, k[0], 1'b0, k[2]});
      chk("bus request", k[0], breq_o);
      chk("width code", k[2:0], gesw);
      chk("pixel size", pix[k % 3], pix_o);
    end
    $display("test engine done");
    wr(8'h51, 8'h1E);
    chk("display bits", 2'b10, dsad);
    chk("cpu bits", 2'b11, cbad);
    chk("width bits", 5'b01011, {lsw, legacy_o, dsad_v, cbad_v});
    wr(8'h51, 8'h0E);
    chk("legacy bit", 1, legacy_o);
    new_dsad_prog_i = 1'b1;
    new_cbad_prog_i = 1'b1;
    @(negedge clock_i);
    chk("base valid", 2'b00, {dsad_v, cbad_v});
    $display("test extension done");
    for (k = 0; k < 3; k++) begin
      wr(8'h53, mvals[k]);
      chk("memory bits", {mvals[k][6], mvals[k][4], mvals[k][0]}, {swp_o, mmio_o, wpb_o});
      rd(8'h53, mvals[k]);
    end
    $display("test memory done");
    wr(8'h39, 8'h40);
    wr(8'h53, 8'h00);
    chk("swap kept", 1, swp_o);
    rd(8'h53, 8'h00);
    wr(8'h39, 8'hBF);
    chk("unlocked", 1, unlocked_o);
    $display("test relock done");
    end_sim();
  end
endmodule // csxr_bank_tb_top
`default_nettype wire
